/* File: hdl/tdm_stream_rate_timing_config.sv */
// Frame timing, stream rates and pin handling of a 16-stream TDM switch.
// Assumes bit clock and frame pulse come from a backplane source and are
// sampled by the 100 MHz clock; config words come from same-clock logic.
`timescale 1ns/1ps

// Summary of operation
// - host address pins, fourteen lines, are captured to select registers
// - bus style pin high or open means data-strobe bus, low separate strobes
// - reset turns off stream drivers, restores defaults, clears counters
// - bidirectional bit forces inputs low and runs output pins two-way
// - each input stream rate comes from its own four-bit rate field
// - each output stream rate comes from its own four-bit rate field
// - output rates are set independently of input rates
// - streams carry 32, 64, 128 or 256 channels per frame by rate
// - enabled input or output channels above 1024 per direction is flagged as unsupported
// - streams are enabled whole, never partly
// - two-bit clock select gives clock frequency and frame pulse width
// - reset default is negative clock and default frame pulse format
// - clock polarity bit selects positive-going clock format
// - frame pulse position and polarity both set select GCI-Bus pulse
// - frame pulse and bit clock set frame boundary and sample instants
// - outputs are timed from the same frame pulse and bit clock
// - drive enable pin high enables the pins of enabled output streams with a usable rate once framed, low floats them
module tdm_stream_rate_timing_config
    import tdm_timing_pkg::*;
#(
    parameter int POWERUP_WAIT = tdm_timing_pkg::POWERUP_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clockEn,
    // configuration words
    input wire logic [tdm_timing_pkg::REG_W-1:0] internalModeRegister,
    input wire logic [tdm_timing_pkg::REG_W-1:0] mainControlRegister,
    input wire logic [tdm_timing_pkg::STREAMS-1:0]
        [tdm_timing_pkg::RATE_W-1:0] inRateField,
    input wire logic [tdm_timing_pkg::STREAMS-1:0]
        [tdm_timing_pkg::RATE_W-1:0] outRateField,
    input wire logic [tdm_timing_pkg::STREAMS-1:0] inStreamEnable,
    input wire logic [tdm_timing_pkg::STREAMS-1:0] outStreamEnable,
    // serial side pins
    input wire logic inputBitClock,
    input wire logic inputFramePulse,
    input wire logic outputDriveEnable,
    input wire logic [tdm_timing_pkg::STREAMS-1:0] serialInputStreams,
    input wire logic [tdm_timing_pkg::STREAMS-1:0] serialOutputStreamsIn,
    output logic [tdm_timing_pkg::STREAMS-1:0] serialOutputStreamsOut,
    output logic [tdm_timing_pkg::STREAMS-1:0] serialOutputStreamsOe,
    // host port pins
    input wire logic busStyleSelect,
    input wire logic [tdm_timing_pkg::ADDR_W-1:0] portAddressLines,
    // transmit bytes, one per output stream, taken at channel start
    input wire logic [tdm_timing_pkg::STREAMS-1:0]
        [tdm_timing_pkg::BYTE_W-1:0] txData,
    // received words {stream, channel, byte}
    output logic rxValid,
    output logic [tdm_timing_pkg::WORD_W-1:0] rxData,
    input wire logic rxReady,
    // status
    output logic frameStart,
    output logic capacityError,
    output logic rateError,
    output logic clockCodeReserved,
    output logic overrun,
    output logic portAccessReady,
    output logic dataStrobeBus,
    output logic [tdm_timing_pkg::ADDR_W-1:0] hostAddress
);
    import tdm_timing_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ckPrev;
        logic framed;
        logic [EDGE_W-1:0] edgeCount;
        logic [STREAMS-1:0][BYTE_W-1:0] inShift;
        logic [STREAMS-1:0][BYTE_W-1:0] inHold;
        logic [STREAMS-1:0][CHAN_W-1:0] inChan;
        logic [STREAMS-1:0] pending;
        logic [STREAMS-1:0][BYTE_W-1:0] outShift;
        logic [STREAMS-1:0] pinOut;
        logic [STREAMS-1:0] pinOe;
        logic frameStart;
        logic capacityErr;
        logic rateErr;
        logic ckReserved;
        logic overrun;
        logic [CNT_W-1:0] readyCnt;
        logic portReady;
        logic busStrobe;
        logic [ADDR_W-1:0] addr;
    } state_s;

    state_s q, d;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    pins_s pinsRaw, pinsSync;

    assign pinsRaw = {inputBitClock, inputFramePulse, outputDriveEnable,
        busStyleSelect, portAddressLines, serialInputStreams,
        serialOutputStreamsIn};

    pin_sync #(.W($bits(pins_s))) pinSyncInst (
        .clock(clock),
        .resetn(resetn),
        .clockEn(clockEn),
        .asyncIn(pinsRaw),
        .syncOut(pinsSync)
    );

    // ------------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------------
    logic bidir, gciPulse, ckActive, fpActive, ckEdge;
    logic [CKSEL_W-1:0] clkSel;
    logic [STREAMS-1:0] inData;

    assign bidir = internalModeRegister[BIDIR_BIT];
    assign clkSel = mainControlRegister[CKSEL_LSB +: CKSEL_W];
    // zero control word means negative clock, active-low pulse
    assign ckActive = mainControlRegister[CK_POL_BIT];
    assign gciPulse = mainControlRegister[FP_POS_BIT]
        && mainControlRegister[FP_POL_BIT];
    assign fpActive = gciPulse ? pinsSync.fp : !pinsSync.fp;
    assign ckEdge = (pinsSync.ck != q.ckPrev)
        && (pinsSync.ck == ckActive);
    // in two-way mode the dedicated inputs are held low; pins read back
    // only while the stream is not driving them
    assign inData = bidir ? (pinsSync.pinIn & ~q.pinOe)
        : pinsSync.serialIn;

    // ------------------------------------------------------------------
    // per-stream rate decode
    // ------------------------------------------------------------------
    rate_cfg_s [STREAMS-1:0] inCfg, outCfg;
    logic [STREAMS-1:0] inOn, outOn, inBitEnd, outBitStart, badRate;
    logic [STREAMS-1:0][EDGE_W-1:0] inPos, outPos;
    logic [STREAMS-1:0][SUM_W-1:0] inChans, outChans;

    genvar g;
    generate
        for (g = 0; g < STREAMS; g++) begin : gStream
            logic [EDGE_W-1:0] inMask;
            logic [EDGE_W-1:0] outMask;
            assign inCfg[g] = rateConfig(clkSel, inRateField[g]);
            assign outCfg[g] = rateConfig(clkSel, outRateField[g]);
            assign inOn[g] = inStreamEnable[g] && inCfg[g].ok;
            assign outOn[g] = outStreamEnable[g] && outCfg[g].ok;
            assign inMask = (EDGE_ONE << inCfg[g].shift) - EDGE_ONE;
            assign outMask = (EDGE_ONE << outCfg[g].shift) - EDGE_ONE;
            assign inPos[g] = q.edgeCount >> inCfg[g].shift;
            assign outPos[g] = q.edgeCount >> outCfg[g].shift;
            assign inBitEnd[g] = (q.edgeCount & inMask) == inMask;
            assign outBitStart[g] = (q.edgeCount & outMask) == EDGE_ZERO;
            assign inChans[g] = inStreamEnable[g]
                ? chanCount(inRateField[g]) : CH_NONE;
            assign outChans[g] = outStreamEnable[g]
                ? chanCount(outRateField[g]) : CH_NONE;
            // a clock too slow for the rate is flagged, not run
            assign badRate[g] = (inStreamEnable[g] && !inCfg[g].ok)
                || (outStreamEnable[g] && !outCfg[g].ok);
        end
    endgenerate

    // ------------------------------------------------------------------
    // received word buffer
    // ------------------------------------------------------------------
    word_stream_if #(.W(WORD_W)) fillBus();
    word_stream_if #(.W(WORD_W)) drainBus();

    word_buffer #(.W(WORD_W)) bufferInst (
        .clock(clock),
        .resetn(resetn),
        .clockEn(clockEn),
        .fill(fillBus.sink),
        .drain(drainBus.source)
    );

    assign rxValid = drainBus.valid;
    assign rxData = drainBus.data;
    assign drainBus.ready = rxReady;

    // lowest pending stream wins; one word a cycle is far above line rate
    logic [SID_W-1:0] pickId;
    always_comb begin
        pickId = '0;
        for (int i = STREAMS - 1; i >= 0; i--) begin
            if (q.pending[i]) begin
                pickId = SID_W'(i);
            end
        end
    end

    assign fillBus.valid = |q.pending;
    assign fillBus.data = {pickId, q.inChan[pickId], q.inHold[pickId]};

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic [SUM_W-1:0] inSum, outSum;
    logic [BYTE_W-1:0] inNext, outSrc;

    always_comb begin
        d = q;
        inSum = CH_NONE;
        outSum = CH_NONE;
        inNext = '0;
        outSrc = '0;
        d.ckPrev = pinsSync.ck;
        d.frameStart = 1'b0;
        d.busStrobe = pinsSync.busStyle;
        d.addr = pinsSync.addr;
        d.ckReserved = (clkSel == CKSEL_RESERVED);
        d.rateErr = |badRate;
        for (int i = 0; i < STREAMS; i++) begin
            inSum = inSum + inChans[i];
            outSum = outSum + outChans[i];
        end
        d.capacityErr = (inSum > MAX_CHANNELS)
            || (outSum > MAX_CHANNELS);
        if (q.readyCnt != CNT_W'(POWERUP_WAIT)) begin
            d.readyCnt = q.readyCnt + 1'b1;
        end
        d.portReady = (q.readyCnt == CNT_W'(POWERUP_WAIT));
        if (fillBus.valid && fillBus.ready) begin
            d.pending[pickId] = 1'b0;
        end
        if (d.ckReserved) begin
            d.framed = 1'b0;
            d.edgeCount = EDGE_ZERO;
        end else if (ckEdge && q.framed) begin
            d.edgeCount = q.edgeCount + EDGE_ONE;
            for (int i = 0; i < STREAMS; i++) begin
                if (inOn[i] && inBitEnd[i]) begin
                    inNext = {q.inShift[i][BYTE_MSB-1:0], inData[i]};
                    d.inShift[i] = inNext;
                    if (inPos[i][2:0] == LAST_BIT) begin
                        // a new byte wins over the pop of the old one
                        d.overrun = q.overrun | d.pending[i];
                        d.pending[i] = 1'b1;
                        d.inHold[i] = inNext;
                        d.inChan[i] = inPos[i][CHAN_LSB +: CHAN_W];
                    end
                end
                if (outOn[i] && outBitStart[i]) begin
                    outSrc = (outPos[i][2:0] == FIRST_BIT)
                        ? txData[i] : q.outShift[i];
                    d.pinOut[i] = outSrc[BYTE_MSB];
                    d.outShift[i] = {outSrc[BYTE_MSB-1:0], 1'b0};
                end
            end
        end
        // the pulse edge still closes the last bit of the old frame
        if (ckEdge && fpActive && !d.ckReserved) begin
            d.framed = 1'b1;
            d.frameStart = 1'b1;
            d.edgeCount = EDGE_ZERO;
        end
        for (int i = 0; i < STREAMS; i++) begin
            d.pinOe[i] = pinsSync.output_drive_enable && outOn[i] && q.framed
                && !d.ckReserved;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (clockEn) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign serialOutputStreamsOut = q.pinOut;
    assign serialOutputStreamsOe = q.pinOe;
    assign frameStart = q.frameStart;
    assign capacityError = q.capacityErr;
    assign rateError = q.rateErr;
    assign clockCodeReserved = q.ckReserved;
    assign overrun = q.overrun;
    assign portAccessReady = q.portReady;
    assign dataStrobeBus = q.busStrobe;
    assign hostAddress = q.addr;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn || !clockEn);
    sequence sFrameSeen;
        ckEdge && fpActive && !d.ckReserved;
    endsequence
    sequence sRestarted;
        q.edgeCount == EDGE_ZERO && q.frameStart && q.framed;
    endsequence
    a_frame_restart: assert property (sFrameSeen |=> sRestarted)
        else $error("frame pulse did not restart the edge count");
    a_drive_gate: assert property (
        !pinsSync.output_drive_enable |=> serialOutputStreamsOe == '0)
        else $error("stream pin driven while drive enable low");
    a_bidir_inputs: assert property (
        bidir |-> (inData & (q.pinOe | ~pinsSync.pinIn)) == '0)
        else $error("two-way input not taken from an idle pin");
    a_capacity_flag: assert property (
        (inSum > MAX_CHANNELS) |=> capacityError)
        else $error("channel overload not flagged");
    a_clock_reserved: assert property (
        clkSel == CKSEL_RESERVED |=> clockCodeReserved
        && serialOutputStreamsOe == '0 && q.edgeCount == EDGE_ZERO)
        else $error("reserved clock code not handled");
    a_bus_style: assert property (
        ##1 dataStrobeBus == $past(pinsSync.busStyle))
        else $error("bus style does not follow its pin");
    a_clock_polarity: assert property (
        ckEdge |-> pinsSync.ck == mainControlRegister[CK_POL_BIT]
        && $past(pinsSync.ck) != pinsSync.ck)
        else $error("active clock edge of wrong polarity");
    a_tx_msb_first: assert property (
        ckEdge && q.framed && !fpActive && !d.ckReserved && outOn[0]
        && outBitStart[0] && outPos[0][2:0] == FIRST_BIT
        |=> serialOutputStreamsOut[0] == $past(txData[0][BYTE_MSB]))
        else $error("channel did not start with its top bit");
    a_rate_flag: assert property (
        inStreamEnable[0] && !inCfg[0].ok |=> rateError)
        else $error("unusable stream rate not flagged");
endmodule

/* File: hdl/tdm_timing_pkg.sv */
// Constants, field layouts and helpers for the TDM front-end timing block.
// Assumes one 100 MHz system clock samples every pin of the serial side.
package tdm_timing_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int STREAMS = 16;
    localparam int RATE_W = 4;
    localparam int ADDR_W = 14;
    localparam int REG_W = 16;
    localparam int EDGE_W = 11;
    localparam int BYTE_W = 8;
    localparam int CHAN_W = 8;
    localparam int SID_W = 4;
    localparam int SUM_W = 13;
    localparam int CNT_W = 16;
    localparam int WORD_W = SID_W + CHAN_W + BYTE_W;
    localparam int BYTE_MSB = BYTE_W - 1;
    localparam int CHAN_LSB = 3;

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int BIDIR_BIT = 6;
    localparam int CKSEL_LSB = 5;
    localparam int CKSEL_W = 2;
    localparam int FP_POL_BIT = 7;
    localparam int CK_POL_BIT = 8;
    localparam int FP_POS_BIT = 9;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [CKSEL_W-1:0] CKSEL_4M = 2'h0;
    localparam logic [CKSEL_W-1:0] CKSEL_8M = 2'h1;
    localparam logic [CKSEL_W-1:0] CKSEL_16M = 2'h2;
    localparam logic [CKSEL_W-1:0] CKSEL_RESERVED = 2'h3;
    localparam logic [RATE_W-1:0] RATE_2M = 4'h1;
    localparam logic [RATE_W-1:0] RATE_4M = 4'h2;
    localparam logic [RATE_W-1:0] RATE_8M = 4'h3;
    localparam logic [RATE_W-1:0] RATE_16M = 4'h4;
    localparam logic [SUM_W-1:0] CH_NONE = 13'h000;
    localparam logic [SUM_W-1:0] CH_2M = 13'h020;
    localparam logic [SUM_W-1:0] CH_4M = 13'h040;
    localparam logic [SUM_W-1:0] CH_8M = 13'h080;
    localparam logic [SUM_W-1:0] CH_16M = 13'h100;
    localparam logic [SUM_W-1:0] MAX_CHANNELS = 13'h400;
    localparam logic [3:0] SHIFT_BASE = 4'h1;
    localparam logic [2:0] FIRST_BIT = 3'h0;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [EDGE_W-1:0] EDGE_ONE = 11'h001;
    localparam logic [EDGE_W-1:0] EDGE_ZERO = 11'h000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int CLK_NS = 10;
    localparam int RESET_MIN_NS = 1000;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int POWERUP_US = 500;
    localparam int POWERUP_CYCLES = POWERUP_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // types and helpers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ok;
        logic [3:0] shift;
    } rate_cfg_s;

    typedef struct packed {
        logic ck;
        logic fp;
        logic output_drive_enable;
        logic busStyle;
        logic [ADDR_W-1:0] addr;
        logic [STREAMS-1:0] serialIn;
        logic [STREAMS-1:0] pinIn;
    } pins_s;

    // clock edges per bit is 2**shift; 16.384 Mbps alone may use one edge
    function automatic rate_cfg_s rateConfig(input logic [1:0] clkSel,
                                             input logic [3:0] rate);
        rate_cfg_s r;
        logic [3:0] top;
        logic [3:0] idx;
        top = {2'h0, clkSel} + SHIFT_BASE;
        idx = rate - RATE_2M;
        r.shift = top - idx;
        r.ok = (rate >= RATE_2M) && (rate <= RATE_16M)
            && (clkSel != CKSEL_RESERVED)
            && ((top > idx) || ((top == idx) && (rate == RATE_16M)));
        return r;
    endfunction

    function automatic logic [SUM_W-1:0] chanCount(input logic [3:0] rate);
        logic [SUM_W-1:0] c;
        case (rate)
            RATE_2M: c = CH_2M;
            RATE_4M: c = CH_4M;
            RATE_8M: c = CH_8M;
            RATE_16M: c = CH_16M;
            default: c = CH_NONE;
        endcase
        return c;
    endfunction

endpackage

/* File: hdl/word_stream_if.sv */
// Valid/ready word carrier between the timing core and its buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 20);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface

/* File: hdl/pin_sync.sv */
// Two-flop synchroniser for a group of pins.
// Assumes the pins are asynchronous to clock; only the second stage leaves.
`timescale 1ns/1ps
module pin_sync #(parameter int W = 1) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clockEn,
    // pins
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb begin
        d = q;
        d.meta = asyncIn;
        d.stable = q.meta;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (clockEn) begin
            q <= d;
        end
    end

    assign syncOut = q.stable;
endmodule

/* File: hdl/word_buffer.sv */
// Two-entry buffer: registered output word plus one spare slot.
// Assumes the filler honours ready; ready is a flop, so no comb path.
`timescale 1ns/1ps
module word_buffer #(parameter int W = 20) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clockEn,
    // streams
    word_stream_if.sink fill,
    word_stream_if.source drain
);
    typedef struct packed {
        logic outValid;
        logic [W-1:0] outData;
        logic spareValid;
        logic [W-1:0] spareData;
    } buf_s;

    buf_s q;
    buf_s d;
    logic push;
    logic pop;

    always_comb begin
        d = q;
        push = fill.valid && !q.spareValid;
        pop = q.outValid && drain.ready;
        if (pop) begin
            d.outValid = q.spareValid;
            d.outData = q.spareData;
            d.spareValid = 1'b0;
        end
        if (push) begin
            if (!q.outValid || pop) begin
                d.outValid = 1'b1;
                d.outData = fill.data;
            end else begin
                d.spareValid = 1'b1;
                d.spareData = fill.data;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else if (clockEn) begin
            q <= d;
        end
    end

    assign fill.ready = !q.spareValid;
    assign drain.valid = q.outValid;
    assign drain.data = q.outData;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn || !clockEn);

    a_buf_hold_word: assert property (
        drain.valid && !drain.ready |=> drain.valid && $stable(drain.data))
        else $error("buffer dropped or changed a stalled word");
endmodule

/* File: dv/tdm_backplane_model.sv */
// Backplane source: bit clock, frame pulse and input stream levels.
// Assumes the bench samples these pins with its own unrelated clock.
`timescale 1ns/1ps
module tdm_backplane_model (
    // pins
    output logic bitClock,
    output logic framePulse,
    output logic [15:0] streams
);
    logic [5:0] edgeCnt = 6'h00;
    initial bitClock = 1'b1;
    always #62.5 bitClock = ~bitClock;
    // short 64-clock frame keeps the run brief; pulse spans a falling edge
    always @(posedge bitClock) edgeCnt <= edgeCnt + 6'h01;
    assign framePulse = (edgeCnt != 6'h00);
    // stream 0 held high, others low: any bit alignment gives FF / 00
    assign streams = 16'h0001;
endmodule

/* File: dv/tdm_stream_rate_timing_config_tb_top.sv */
// Self-checking bench for the TDM timing and configuration block.
// Assumes the backplane model drives the serial side at 8 MHz, a 125 ns bit clock.
`timescale 1ns/1ps
module tdm_stream_rate_timing_config_tb_top;
    import tdm_timing_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, clockEn = 1'b1, rxReady = 1'b1;
    logic [15:0] internalModeRegister = 16'h0000;
    logic [15:0] mainControlRegister = 16'h0020;
    logic [15:0][3:0] inRateField = '0, outRateField = '0;
    logic [15:0][7:0] txData = '0;
    logic [15:0] inStreamEnable = '0, outStreamEnable = '0;
    logic [15:0] serialInputStreams, serialOutputStreamsIn;
    logic [15:0] serialOutputStreamsOut, serialOutputStreamsOe;
    logic outputDriveEnable = 1'b0, busStyleSelect = 1'b1;
    logic inputBitClock, inputFramePulse, rxValid, frameStart, overrun;
    logic capacityError, rateError, clockCodeReserved;
    logic portAccessReady, dataStrobeBus;
    logic [13:0] portAddressLines = 14'h0000, hostAddress;
    logic [19:0] rxData, w;
    int error_cnt = 0, num_checks = 0;
    // pins have pull-downs: released wire reads low
    assign serialOutputStreamsIn = serialOutputStreamsOut
        & serialOutputStreamsOe;
    always #5 clock = ~clock;
    tdm_backplane_model u_tdm_backplane_model (.bitClock(inputBitClock),
        .framePulse(inputFramePulse), .streams(serialInputStreams));
    tdm_stream_rate_timing_config #(.POWERUP_WAIT(20))
        u_tdm_stream_rate_timing_config (.clock, .resetn, .clockEn,
        .internalModeRegister, .mainControlRegister, .inRateField,
        .outRateField, .inStreamEnable, .outStreamEnable, .inputBitClock,
        .inputFramePulse, .outputDriveEnable, .serialInputStreams,
        .serialOutputStreamsIn, .serialOutputStreamsOut,
        .serialOutputStreamsOe, .busStyleSelect, .portAddressLines,
        .txData, .rxValid, .rxData, .rxReady, .frameStart, .capacityError,
        .rateError, .clockCodeReserved, .overrun, .portAccessReady,
        .dataStrobeBus, .hostAddress);
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [19:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic getWord();
        int i;
        i = 0;
        while (rxValid !== 1'b1 && i < 3000) begin
            cyc(1);
            i++;
        end
        chk("rxValid", rxValid, 1'b1);
        w = rxData;
        cyc(1);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic testReset();
        chk("oe", serialOutputStreamsOe, 16'h0000);
        chk("rxValid", rxValid, 1'b0);
        cyc(20);
        chk("accessEarly", portAccessReady, 1'b0);
        cyc(4);
        chk("accessLate", portAccessReady, 1'b1);
    endtask
    task automatic testHost();
        busStyleSelect = 1'b0;
        portAddressLines = 14'h2A5C;
        cyc(4);
        chk("style", dataStrobeBus, 1'b0);
        chk("addr", hostAddress, 14'h2A5C);
        busStyleSelect = 1'b1;
        cyc(4);
        chk("style", dataStrobeBus, 1'b1);
    endtask
    task automatic testCapacity();
        inRateField = {16{4'h2}};
        inStreamEnable = 16'hFFFF;
        cyc(4);
        chk("cap", capacityError, 1'b0);
        chk("rate", rateError, 1'b0);
        inRateField[0] = 4'h3;
        cyc(4);
        chk("cap", capacityError, 1'b1);
        chk("rate", rateError, 1'b1);
        mainControlRegister = 16'h0060;
        cyc(4);
        chk("ckRes", clockCodeReserved, 1'b1);
        mainControlRegister = 16'h0020;
        inRateField[0] = 4'h2;
    endtask
    task automatic testStream();
        logic [7:0] b;
        inStreamEnable = 16'h0003;
        outStreamEnable = 16'h0001;
        outRateField[0] = 4'h3;
        outputDriveEnable = 1'b1;
        for (int i = 0; i < 6; i++) begin
            getWord();
            if (i > 1) chk("byte", w[7:0], w[19:16] ? 8'h00 : 8'hFF);
        end
        chk("oe", serialOutputStreamsOe, 16'h0000);
        outRateField[0] = 4'h2;
        cyc(900);
        chk("oe", serialOutputStreamsOe, 16'h0001);
        b = 8'h00;
        txData[0] = 8'hA5;
        // sample mid-bit: bits last two active edges, 25 clocks
        while (frameStart !== 1'b1) cyc(1);
        repeat (8) begin
            cyc(25);
            b = {b[6:0], serialOutputStreamsOut[0]};
        end
        chk("txByte", b, 8'hA5);
        outputDriveEnable = 1'b0;
        cyc(5);
        chk("oe", serialOutputStreamsOe, 16'h0000);
    endtask
    task automatic testBidir();
        internalModeRegister = 16'h0040;
        inStreamEnable = 16'h0001;
        cyc(300);
        repeat (3) getWord();
        chk("bidir", {w[19:16], w[7:0]}, 12'h000);
        chk("ovr", overrun, 1'b0);
    endtask
    task automatic testMidReset();
        resetn = 1'b0;
        cyc(RESET_MIN_CYCLES + 1);
        chk("rstReady", portAccessReady, 1'b0);
        chk("rstOvr", overrun, 1'b0);
        resetn = 1'b1;
        testReset();
    endtask
    initial begin
        cyc(2);
        resetn = 1'b1;
        testReset();
        testHost();
        testCapacity();
        testStream();
        testBidir();
        testMidReset();
        conclude();
    end
    initial begin
        #300us;
        error_cnt++;
        conclude();
    end
endmodule
